//--- design/ocm_regs.vh
`ifndef OCM_REGS_VH
`define OCM_REGS_VH

// register byte offsets
`define OCM_REG_RAM_ADDR 8'hA0
`define OCM_REG_RAM_DATA1 8'hA4
`define OCM_REG_CMD_STAT 8'hA8
`define OCM_REG_RAM_DATA2 8'hAC
`define OCM_REG_IRQ_STAT 8'hB0
`define OCM_REG_IRQ_MASK 8'hB4

// command word fields
`define OCM_CMD_PROG 0
`define OCM_CMD_SEL_LO 1
`define OCM_CMD_SEL_HI 4
`define OCM_CMD_READBACK 6
`define OCM_CMD_DIV_SET 7
`define OCM_CMD_DIV_LO 8
`define OCM_CMD_DIV_HI 23

// status word fields
`define OCM_STAT_DONE 0
`define OCM_STAT_ERR 1
`define OCM_STAT_MEAS 2

// interrupt status bits
`define OCM_IRQ_PROG_DONE 0
`define OCM_IRQ_PROG_ERR 1
`define OCM_IRQ_MEAS_DONE 2

// setup memory span sent to the generator
`define OCM_SETUP_FIRST 8'h08
`define OCM_SETUP_LAST 8'h57

// generator serial bus addresses (arbitrary defaults)
`define OCM_GEN1_ADDR 7'h69
`define OCM_GEN2_ADDR 7'h6A

// reset values
`define OCM_RST_CMD 24'h000000
`define OCM_RST_DIV 16'h0000
`define OCM_RST_DONE 1'b1

// timing
`define OCM_CLK_NS 10
`define OCM_GATE_NS 100000000
`define OCM_QUARTER_NS 625

`endif

//--- design/ocm_postdiv.v
`timescale 1ns/1ps
// power-of-two divider for one channel clock, sampled at the system clock
module ocm_postdiv #(
   parameter DIV_W = 4, // width of exponent field
   parameter CNT_W = 15 // counter width, largest exponent minus zero
)
(
   input wire clock, // system clock
   input wire reset, // synchronous reset, active high
   input wire clk_in, // raw channel clock level
   input wire [DIV_W-1:0] div_n, // exponent n, divide by 2**n
   output reg clk_out // divided channel clock level
);
   reg in_prev_q; // previous input level for edge detect
   reg [CNT_W-1:0] cnt_q; // rising edges counted since last toggle
   wire rise = clk_in & ~in_prev_q; // rising edge of input
   wire [CNT_W:0] half = {{CNT_W{1'b0}}, 1'b1} << div_n; // 2**n
   wire [CNT_W-1:0] limit = half[CNT_W:1] - {{(CNT_W-1){1'b0}}, 1'b1}; // 2**(n-1) - 1

   // toggle output every 2**(n-1) rising edges; n of zero passes input
   always @(posedge clock)
   begin
      if (reset)
      begin
         in_prev_q <= 1'b0;
         cnt_q <= {CNT_W{1'b0}};
         clk_out <= 1'b0;
      end
      else
      begin
         in_prev_q <= clk_in;
         if (div_n == {DIV_W{1'b0}})
         begin
            clk_out <= clk_in; // undivided
            cnt_q <= {CNT_W{1'b0}};
         end
         else if (rise)
         begin
            if (cnt_q >= limit)
            begin
               cnt_q <= {CNT_W{1'b0}};
               clk_out <= ~clk_out; // divide by 2**n
            end
            else
            begin
               cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // ocm_postdiv

//--- design/ocm_top.v
`timescale 1ns/1ps
`include "ocm_regs.vh"
// oscillator programming and channel clock measurement
module ocm_top #(
   parameter GATE_CYCLES = `OCM_GATE_NS / `OCM_CLK_NS, // measurement gate length in cycles
   parameter QUARTER_CYCLES = (`OCM_QUARTER_NS + `OCM_CLK_NS - 1) / `OCM_CLK_NS // quarter serial bit
)
(
   input wire clock, // system clock, 100 MHz
   input wire reset, // synchronous reset, active high
   input wire [7:0] avs_address, // byte address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // byte lanes
   output reg [31:0] avs_readdata, // read data
   output reg avs_waitrequest, // stall until answer
   output reg irq, // level interrupt
   input wire osc_clock_1, // generator output for channel one
   input wire osc_clock_2, // generator output for channel two
   input wire osc_clock_3, // generator output for channel three
   input wire osc_clock_4, // generator output for channel four
   output wire channel_one_baud_clock, // divided channel one clock
   output wire channel_two_baud_clock, // divided channel two clock
   output wire channel_three_baud_clock, // divided channel three clock
   output wire channel_four_baud_clock, // divided channel four clock
   output reg gen_scl, // generator serial clock
   input wire gen_sda_in, // generator serial data level
   output reg gen_sda_out, // serial data drive value, always low
   output reg gen_sda_oe_n // low while pulling data line low
);
   localparam ST_IDLE = 3'd0; // engine idle
   localparam ST_START = 3'd1; // start condition
   localparam ST_BYTE = 3'd2; // shifting a byte plus ack
   localparam ST_STOP = 3'd3; // stop condition
   localparam ST_DONE = 3'd4; // report finish
   localparam [7:0] LAST_SPAN = 8'h02 + (`OCM_SETUP_LAST - `OCM_SETUP_FIRST); // address, pointer, then data
   localparam [6:0] LAST_IDX = LAST_SPAN[6:0]; // last byte slot

   reg [7:0] setup_memory_first [0:255]; // setup for first generator
   reg [7:0] setup_memory_second [0:255]; // setup for second generator
   reg [7:0] ram_addr_q; // indirect memory index
   reg [23:0] cmd_q; // command bits kept for readback
   reg [15:0] div_q; // four post-divider exponents
   reg [1:0] sel_q; // measured channel
   reg meas_run_q; // measurement gate open
   reg meas_done_q; // measurement complete
   reg [31:0] gate_q; // gate cycle counter
   reg [23:0] edges_q; // edges in current gate
   reg [23:0] result_q; // last measurement result
   reg meas_prev_q; // previous level of measured clock
   reg [2:0] st_q; // programming state
   reg gen_q; // which generator is served
   reg [6:0] idx_q; // byte slot within frame
   reg [3:0] bit_q; // bit within byte, 8 is ack
   reg [1:0] ph_q; // quarter phase within bit
   reg [7:0] sh_q; // outgoing byte
   reg [15:0] tick_q; // quarter-bit divider
   reg done_q; // programming finished
   reg err_q; // programming failed
   reg [2:0] irq_stat_q; // sticky event bits
   reg [2:0] irq_mask_q; // event enables
   wire [2:0] ev = (st_q == ST_DONE) ? {1'b0, err_q, 1'b1} : 3'b000; // event pulses: error, done
   reg [31:0] rd_mux; // read data selection
   reg [7:0] next_byte; // byte for the next slot
   wire [3:0] div_clk; // divided channel clocks
   wire tick = (tick_q == 16'h0000); // quarter-bit enable
   wire wr_fire = avs_write & ~avs_waitrequest; // write takes effect
   wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}}; // lane mask
   wire [31:0] wd = avs_writedata & wmask; // lane-gated data
   wire cmd_wr = wr_fire & (avs_address == `OCM_REG_CMD_STAT); // command write
   wire [3:0] sel_bits = wd[`OCM_CMD_SEL_HI:`OCM_CMD_SEL_LO]; // channel select bits
   wire meas_clk = div_clk[sel_q]; // divided clock under
   wire [1:0] sel_new = sel_bits[0] ? 2'd0 : sel_bits[1] ? 2'd1 : sel_bits[2] ? 2'd2 : 2'd3; // lowest set bit wins
   wire meas_inc = meas_clk & ~meas_prev_q & (edges_q != 24'hFFFFFF); // counted rise, saturating

   // four post-dividers, one per channel
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_div
         wire raw = (g == 0) ? osc_clock_1 : (g == 1) ? osc_clock_2 :
                    (g == 2) ? osc_clock_3 : osc_clock_4; // raw clock
         ocm_postdiv #(.DIV_W(4), .CNT_W(15)) u_div (
            .clock(clock),
            .reset(reset),
            .clk_in(raw),
            .div_n(div_q[g*4+3:g*4]),
            .clk_out(div_clk[g])
         );
      end
   endgenerate
   assign channel_one_baud_clock = div_clk[0];
   assign channel_two_baud_clock = div_clk[1];
   assign channel_three_baud_clock = div_clk[2];
   assign channel_four_baud_clock = div_clk[3];

   // bus answer: waitrequest drops one cycle after a request appears
   always @(posedge clock)
   begin
      if (reset)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end
      else if ((avs_read | avs_write) & avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0; // answer next cycle
         avs_readdata <= avs_read ? rd_mux : 32'h00000000;
      end
      else
      begin
         avs_waitrequest <= 1'b1;
      end
   end

   // read decode; unmapped addresses read zero
   always @*
   begin
      rd_mux = 32'h00000000;
      case (avs_address)
         `OCM_REG_RAM_ADDR: rd_mux = {24'h000000, ram_addr_q};
         `OCM_REG_RAM_DATA1: rd_mux = {24'h000000, setup_memory_first[ram_addr_q]};
         `OCM_REG_RAM_DATA2: rd_mux = {24'h000000, setup_memory_second[ram_addr_q]};
         `OCM_REG_CMD_STAT: // status word
         begin
            rd_mux[`OCM_STAT_DONE] = done_q;
            rd_mux[`OCM_STAT_ERR] = err_q;
            rd_mux[`OCM_STAT_MEAS] = meas_done_q;
            rd_mux[31:8] = cmd_q[`OCM_CMD_READBACK] ? cmd_q : result_q;
         end
         `OCM_REG_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_q};
         `OCM_REG_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // setup memories written through the indirect window
   always @(posedge clock)
   begin
      if (wr_fire & avs_byteenable[0] & (avs_address == `OCM_REG_RAM_DATA1))
      begin
         setup_memory_first[ram_addr_q] <= avs_writedata[7:0];
      end
      if (wr_fire & avs_byteenable[0] & (avs_address == `OCM_REG_RAM_DATA2))
      begin
         setup_memory_second[ram_addr_q] <= avs_writedata[7:0];
      end
   end

   // command, divider and index registers
   always @(posedge clock)
   begin
      if (reset)
      begin
         ram_addr_q <= 8'h00;
         cmd_q <= `OCM_RST_CMD;
         div_q <= `OCM_RST_DIV;
         irq_mask_q <= 3'h0;
      end
      else if (wr_fire)
      begin
         if ((avs_address == `OCM_REG_RAM_ADDR) & avs_byteenable[0])
         begin
            ram_addr_q <= avs_writedata[7:0];
         end
         if (avs_address == `OCM_REG_IRQ_MASK)
         begin
            irq_mask_q <= wd[2:0];
         end
         if (cmd_wr)
         begin
            cmd_q <= {wd[23:1], 1'b0}; // program bit never held
            if (wd[`OCM_CMD_DIV_SET])
            begin
               div_q <= wd[`OCM_CMD_DIV_HI:`OCM_CMD_DIV_LO];
            end // else dividers untouched
         end
      end
   end

   // measurement: count divided-clock edges over a fixed gate
   always @(posedge clock)
   begin
      if (reset)
      begin
         sel_q <= 2'd0;
         meas_run_q <= 1'b0;
         meas_done_q <= 1'b0;
         gate_q <= 32'h00000000;
         edges_q <= 24'h000000;
         result_q <= 24'h000000;
         meas_prev_q <= 1'b0;
      end
      else
      begin
         meas_prev_q <= meas_clk;
         if (cmd_wr & (sel_bits != 4'h0))
         begin
            sel_q <= sel_new;
            meas_prev_q <= div_clk[sel_new]; // no false edge from the old channel
            meas_run_q <= 1'b1;
            meas_done_q <= 1'b0;
            gate_q <= 32'h00000000;
            edges_q <= 24'h000000;
         end
         else if (meas_run_q)
         begin
            if (meas_inc)
            begin
               edges_q <= edges_q + 24'h000001;
            end
            if (gate_q == GATE_CYCLES - 1)
            begin
               meas_run_q <= 1'b0;
               meas_done_q <= 1'b1;
               result_q <= edges_q + {23'h000000, meas_inc}; // last gate cycle counts too
            end
            else
            begin
               gate_q <= gate_q + 32'h00000001;
            end
         end
      end
   end

   // byte for the slot after the current one
   always @*
   begin
      next_byte = 8'h00;
      if (idx_q == 7'd0)
      begin
         next_byte = `OCM_SETUP_FIRST; // register pointer follows address
      end
      else if (gen_q)
      begin
         next_byte = setup_memory_second[`OCM_SETUP_FIRST + {1'b0, idx_q} - 8'h01];
      end
      else
      begin
         next_byte = setup_memory_first[`OCM_SETUP_FIRST + {1'b0, idx_q} - 8'h01];
      end
   end

   // programming engine: serial frames to first then second generator; an error on the first skips the second
   always @(posedge clock)
   begin
      if (reset)
      begin
         st_q <= ST_IDLE;
         gen_q <= 1'b0;
         idx_q <= 7'd0;
         bit_q <= 4'd0;
         ph_q <= 2'd0;
         sh_q <= 8'h00;
         tick_q <= 16'h0000;
         done_q <= `OCM_RST_DONE;
         err_q <= 1'b0;
         gen_scl <= 1'b1;
         gen_sda_out <= 1'b0;
         gen_sda_oe_n <= 1'b1;
      end
      else
      begin
         tick_q <= tick ? QUARTER_CYCLES[15:0] - 16'h0001 : tick_q - 16'h0001;
         case (st_q)
            ST_IDLE:
            begin
               if (cmd_wr & wd[`OCM_CMD_PROG])
               begin
                  st_q <= ST_START;
                  done_q <= 1'b0;
                  err_q <= 1'b0;
                  gen_q <= 1'b0;
                  ph_q <= 2'd0;
               end
            end
            ST_START:
            begin
               if (tick)
               begin
                  ph_q <= ph_q + 2'd1;
                  if (ph_q == 2'd0) gen_sda_oe_n <= 1'b0; // data falls, clock high
                  if (ph_q == 2'd1) gen_scl <= 1'b0;
                  if (ph_q == 2'd3)
                  begin
                     st_q <= ST_BYTE;
                     idx_q <= 7'd0;
                     bit_q <= 4'd0;
                     sh_q <= {gen_q ? `OCM_GEN2_ADDR : `OCM_GEN1_ADDR, 1'b0};
                  end
               end
            end
            ST_BYTE:
            begin
               if (tick)
               begin
                  ph_q <= ph_q + 2'd1;
                  case (ph_q)
                     2'd0: gen_sda_oe_n <= (bit_q == 4'd8) ? 1'b1 : sh_q[7]; // msb first
                     2'd1: gen_scl <= 1'b1;
                     2'd2:
                     begin
                        if ((bit_q == 4'd8) & gen_sda_in)
                        begin
                           err_q <= 1'b1; // no acknowledge
                        end
                     end
                     default:
                     begin
                        gen_scl <= 1'b0;
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'd1;
                        if (bit_q == 4'd8)
                        begin
                           bit_q <= 4'd0;
                           if (err_q | (idx_q == LAST_IDX))
                           begin
                              st_q <= ST_STOP;
                           end
                           else
                           begin
                              idx_q <= idx_q + 7'd1; // address order
                              sh_q <= next_byte;
                           end
                        end
                     end
                  endcase
               end
            end
            ST_STOP:
            begin
               if (tick)
               begin
                  ph_q <= ph_q + 2'd1;
                  if (ph_q == 2'd0) gen_sda_oe_n <= 1'b0;
                  if (ph_q == 2'd1) gen_scl <= 1'b1;
                  if (ph_q == 2'd2) gen_sda_oe_n <= 1'b1; // data rises, clock high
                  if (ph_q == 2'd3)
                  begin
                     if (err_q | gen_q)
                     begin
                        st_q <= ST_DONE;
                     end
                     else
                     begin
                        gen_q <= 1'b1; // second generator next
                        st_q <= ST_START;
                     end
                  end
               end
            end
            ST_DONE:
            begin
               done_q <= 1'b1; // after the last byte
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // sticky event bits, write one to clear, set wins
   always @(posedge clock)
   begin
      if (reset)
      begin
         irq_stat_q <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~((wr_fire & (avs_address == `OCM_REG_IRQ_STAT)) ? wd[2:0] : 3'h0))
                       | ev | {meas_run_q & (gate_q == GATE_CYCLES - 1) & ~cmd_wr, 2'b00};
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule // ocm_top

//--- design/ocm_top_unused_guard.v
`timescale 1ns/1ps
// intentionally left without modules

//--- sim/ocm_gen_model.sv
`timescale 1ns/1ps
// serial programming port of the external clock generator
module ocm_gen_model
(
   input wire scl, // serial clock from the block
   input wire sda, // resolved data line level
   input wire nack, // refuse every byte when high
   output reg ack_low = 1'b0, // pulls the data line low
   output reg [7:0] rx_byte = 8'h00, // last byte taken
   output integer rx_cnt = 0 // bytes taken so far
);
   reg [3:0] bit_n = 4'h0; // bit position within a byte
   reg [7:0] shift_q = 8'h00; // incoming byte, msb first
   // a start or stop condition restarts the byte framing
   always @(sda)
      if (scl === 1'b1)
         bit_n = 4'h0;
   // take one data bit on each of the first eight rising serial clocks of a byte
   always @(posedge scl)
   begin
      if (bit_n < 4'h8)
         shift_q = {shift_q[6:0], sda};
      bit_n = bit_n + 4'h1;
      if (bit_n == 4'h8)
      begin
         rx_byte = shift_q;
         rx_cnt = rx_cnt + 1;
      end
      if (bit_n == 4'h9)
         bit_n = 4'h0;
   end
   // answer during the ninth bit only; afterwards the pull-up owns the line
   always @(negedge scl)
      ack_low = (bit_n == 4'h8) && !nack;
endmodule // ocm_gen_model

//--- sim/ocm_top_properties.sv
`timescale 1ns/1ps
`include "ocm_regs.vh"
// bus, link and interrupt relations seen at the block pins
module ocm_top_props
(
   input wire clock, // system clock
   input wire reset, // synchronous reset
   input wire [7:0] avs_address, // byte address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // byte lanes
   input wire [31:0] avs_readdata, // read data
   input wire avs_waitrequest, // stall
   input wire irq, // level interrupt
   input wire osc_clock_1, // raw channel one clock
   input wire channel_one_baud_clock, // divided channel one clock
   input wire gen_scl, // serial clock
   input wire gen_sda_out, // data drive value
   input wire gen_sda_oe_n // data drive enable, low active
);
   reg [31:0] cmd_q; // command word shadow
   reg [2:0] mask_q; // interrupt mask shadow
   reg [3:0] div1_q; // channel one exponent shadow
   wire take_w = avs_write && !avs_waitrequest; // write lands here
   wire ask = (avs_read || avs_write) && avs_waitrequest; // request first seen
   wire stat_rd = avs_read && avs_waitrequest && (avs_address == `OCM_REG_CMD_STAT); // status read
   wire [31:0] lanes = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
      {8{avs_byteenable[0]}}}; // lane mask
   wire mapped = (avs_address == `OCM_REG_RAM_ADDR) || (avs_address == `OCM_REG_RAM_DATA1) ||
      (avs_address == `OCM_REG_CMD_STAT) || (avs_address == `OCM_REG_RAM_DATA2) ||
      (avs_address == `OCM_REG_IRQ_STAT) || (avs_address == `OCM_REG_IRQ_MASK); // decoded place
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // shadows follow the writes that land
   always @(posedge clock)
      if (reset)
      begin
         cmd_q <= 32'h0;
         mask_q <= 3'h0;
         div1_q <= 4'h0;
      end
      else if (take_w && (avs_address == `OCM_REG_CMD_STAT))
      begin
         cmd_q <= avs_writedata & lanes;
         if (avs_writedata[7] && avs_byteenable[0] && avs_byteenable[1])
            div1_q <= avs_writedata[11:8];
      end
      else if (take_w && (avs_address == `OCM_REG_IRQ_MASK))
         mask_q <= avs_writedata[2:0] & lanes[2:0];
   AST_ANSWER_ONE: assert property (ask |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   AST_ANSWER_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer stood longer than one cycle");
   AST_UNMAPPED_ZERO: assert property (avs_read && avs_waitrequest && !mapped |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_STATUS_RSV: assert property (stat_rd |=> avs_readdata[7:3] == 5'h00)
      else $error("status reserved bits not zero");
   AST_READBACK: assert property (stat_rd && cmd_q[6] |=> avs_readdata[31:8] == {cmd_q[23:1], 1'b0})
      else $error("status upper bits differ from command word");
   AST_READ_HOLD: assert property (!$past(reset) && avs_waitrequest |-> $stable(avs_readdata))
      else $error("read data moved outside an answer");
   AST_PROG_START: assert property (take_w && (avs_address == `OCM_REG_CMD_STAT) && avs_writedata[0]
      && avs_byteenable[0] |-> ##[1:40] !gen_scl)
      else $error("program command did not start the link");
   AST_DRIVE_LOW: assert property (!gen_sda_oe_n |-> gen_sda_out == 1'b0)
      else $error("data line driven high");
   AST_IRQ_MASKED: assert property ((mask_q == 3'h0) && $past(mask_q == 3'h0) |-> !irq)
      else $error("interrupt raised while fully masked");
   AST_DIV_ZERO: assert property (!$past(reset) && (div1_q == 4'h0) && $past(div1_q == 4'h0, 3)
      |-> channel_one_baud_clock == $past(osc_clock_1))
      else $error("undivided channel clock does not follow input");
   cover property (take_w && (avs_address == `OCM_REG_CMD_STAT) && avs_writedata[0]);
   cover property ($rose(irq));
   cover property (avs_read && !avs_waitrequest && (avs_address == `OCM_REG_CMD_STAT) && avs_readdata[2]);
endmodule // ocm_top_props
bind ocm_top ocm_top_props u_props (.clock(clock), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .osc_clock_1(osc_clock_1),
   .channel_one_baud_clock(channel_one_baud_clock), .gen_scl(gen_scl), .gen_sda_out(gen_sda_out),
   .gen_sda_oe_n(gen_sda_oe_n));

//--- sim/ocm_top_tb.sv
`timescale 1ns/1ps
`include "ocm_regs.vh"
// bench: registers over the bus, generator model on the link
module ocm_top_tb;
   reg clock = 1'b0; // system clock
   reg reset = 1'b1; // synchronous reset
   reg [7:0] avs_address = 8'h00; // bus address
   reg avs_read = 1'b0; // bus read
   reg avs_write = 1'b0; // bus write
   reg [31:0] avs_writedata = 32'h0; // bus write data
   reg [3:0] avs_byteenable = 4'hF; // all lanes
   reg [4:0] osc_cnt = 5'h00; // raw clocks, period four cycles
   reg nack = 1'b0; // model refuses bytes
   wire [31:0] avs_readdata; // bus read data
   wire avs_waitrequest, irq, gen_scl, gen_sda_out, gen_sda_oe_n, ack_low; // dut and model outputs
   wire [3:0] baud; // divided channel clocks
   wire [7:0] rx_byte; // byte seen by model
   wire sda = gen_sda_oe_n & ~ack_low; // pulled-up data line
   integer rx_cnt, i, k, lo, miscompares = 0, n_compared = 0, seed = 32'h16D7;
   reg [31:0] rd, m, e; // read result, mask, expectation
   reg [31:0] exp_q[$], msk_q[$]; // read expectations
   reg [7:0] byte_q[$], mem1[0:255], mem2[0:255]; // link expectations, memory images
   ocm_top #(.GATE_CYCLES(100), .QUARTER_CYCLES(2)) dut (.clock(clock), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .osc_clock_1(osc_cnt[1]),
      .osc_clock_2(osc_cnt[1]), .osc_clock_3(osc_cnt[1]), .osc_clock_4(osc_cnt[1]),
      .channel_one_baud_clock(baud[0]), .channel_two_baud_clock(baud[1]), .channel_three_baud_clock(baud[2]),
      .channel_four_baud_clock(baud[3]), .gen_scl(gen_scl), .gen_sda_in(sda), .gen_sda_out(gen_sda_out),
      .gen_sda_oe_n(gen_sda_oe_n));
   ocm_gen_model u_gen (.scl(gen_scl), .sda(sda), .nack(nack), .ack_low(ack_low), .rx_byte(rx_byte),
      .rx_cnt(rx_cnt));
   // clock and raw channel clocks
   always #5 clock = ~clock;
   always @(posedge clock) osc_cnt <= osc_cnt + 5'h01;
   task check(input [8*10:1] name, input [31:0] seen, input [31:0] exp);
   begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("[ERR] %0s expected %h seen %h", name, exp, seen);
      end
   end
   endtask
   task end_sim;
   begin
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if ((miscompares == 0) && (n_compared > 0))
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   // one bus access; a read notes its expectation, mask zero means unchecked
   task bus(input [7:0] a, input w, input [31:0] d, input [31:0] mk);
      integer t;
   begin
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      if (!w)
      begin
         exp_q.push_back(d & mk);
         msk_q.push_back(mk);
      end
      t = 0;
      @(posedge clock);
      while ((avs_waitrequest !== 1'b0) && (t < 50))
      begin
         @(posedge clock);
         t = t + 1;
      end
      if (t >= 50) miscompares = miscompares + 1;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   end
   endtask
   // poll the status word until a bit is set
   task poll(input integer b);
      integer t;
   begin
      t = 0;
      rd = 32'h0;
      while ((rd[b] !== 1'b1) && (t < 6000))
      begin
         bus(`OCM_REG_CMD_STAT, 1'b0, 32'h0, 32'h0);
         t = t + 1;
      end
      if (t >= 6000) miscompares = miscompares + 1;
   end
   endtask
   // read answers compared against the oldest note
   always @(posedge clock)
      if ((avs_read === 1'b1) && (avs_waitrequest === 1'b0))
      begin
         m = msk_q.pop_front();
         e = exp_q.pop_front();
         if (m != 32'h0) check("readdata", avs_readdata & m, e);
      end
   // bytes taken by the generator compared in order
   always @(rx_cnt)
      if (rx_cnt > 0) check("link_byte", {24'h0, rx_byte}, {24'h0, byte_q.pop_front()});
   // watchdog
   initial
   begin
      repeat (60000) @(posedge clock);
      miscompares = miscompares + 1;
      end_sim;
   end
   initial
   begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      bus(`OCM_REG_CMD_STAT, 1'b0, 32'h1, 32'hFFFFFFFF);
      bus(8'h10, 1'b0, 32'h0, 32'hFFFFFFFF);
      bus(`OCM_REG_IRQ_MASK, 1'b1, 32'h7, 32'h0);
      for (i = 8; i <= 8'h57; i = i + 1)
      begin
         mem1[i] = $random(seed);
         mem2[i] = $random(seed);
         bus(`OCM_REG_RAM_ADDR, 1'b1, i, 32'h0);
         bus(`OCM_REG_RAM_DATA1, 1'b1, {24'h0, mem1[i]}, 32'h0);
         bus(`OCM_REG_RAM_DATA2, 1'b1, {24'h0, mem2[i]}, 32'h0);
      end
      bus(`OCM_REG_RAM_ADDR, 1'b1, 32'h30, 32'h0);
      bus(`OCM_REG_RAM_DATA1, 1'b0, {24'h0, mem1[8'h30]}, 32'hFF);
      bus(`OCM_REG_RAM_DATA2, 1'b0, {24'h0, mem2[8'h30]}, 32'hFF);
      byte_q.push_back({`OCM_GEN1_ADDR, 1'b0});
      byte_q.push_back(`OCM_SETUP_FIRST);
      for (i = 8; i <= 8'h57; i = i + 1) byte_q.push_back(mem1[i]);
      byte_q.push_back({`OCM_GEN2_ADDR, 1'b0});
      byte_q.push_back(`OCM_SETUP_FIRST);
      for (i = 8; i <= 8'h57; i = i + 1) byte_q.push_back(mem2[i]);
      bus(`OCM_REG_CMD_STAT, 1'b1, 32'h1, 32'h0);
      bus(`OCM_REG_CMD_STAT, 1'b0, 32'h0, 32'h1);
      poll(0);
      bus(`OCM_REG_CMD_STAT, 1'b0, 32'h1, 32'h3);
      check("irq", {31'h0, irq}, 32'h1);
      bus(`OCM_REG_IRQ_STAT, 1'b0, 32'h1, 32'h1);
      bus(`OCM_REG_IRQ_STAT, 1'b1, 32'h7, 32'h0);
      bus(`OCM_REG_IRQ_MASK, 1'b1, 32'h0, 32'h0);
      @(posedge clock);
      check("irq", {31'h0, irq}, 32'h0);
      nack <= 1'b1;
      byte_q.push_back({`OCM_GEN1_ADDR, 1'b0});
      bus(`OCM_REG_CMD_STAT, 1'b1, 32'h1, 32'h0);
      poll(0);
      bus(`OCM_REG_CMD_STAT, 1'b0, 32'h3, 32'h3);
      check("irq", {31'h0, irq}, 32'h0);
      bus(`OCM_REG_IRQ_MASK, 1'b1, 32'h2, 32'h0);
      @(posedge clock);
      check("irq", {31'h0, irq}, 32'h1);
      bus(`OCM_REG_IRQ_STAT, 1'b1, 32'h7, 32'h0);
      nack <= 1'b0;
      bus(`OCM_REG_CMD_STAT, 1'b1, 32'h003210C0, 32'h0);
      bus(`OCM_REG_CMD_STAT, 1'b0, 32'h3210C000, 32'hFFFFFF00);
      for (k = 1; k <= 4; k = k + 1)
      begin
         bus(`OCM_REG_CMD_STAT, 1'b1, 32'h00FFFF00 | (32'h1 << k), 32'h0);
         bus(`OCM_REG_CMD_STAT, 1'b0, 32'h0, 32'h4);
         poll(2);
         lo = 100 / (4 << (k - 1));
         check("result", {31'h0, (rd[31:8] >= lo) && (rd[31:8] <= lo + 1)}, 32'h1);
      end
      check("link_left", byte_q.size(), 32'h0);
      end_sim;
   end
endmodule // ocm_top_tb
